// ===== asu_async_serial_unit.sv
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - detect parity, framing, overrun errors; any error raises an error request unless merge bit 0 is set
// - reading the error status returns flags then clears them to zero
// - parity error when received parity disagrees with configured odd or even parity; zero parity is not checked
// - framing error when stop bit position samples low
// - overrun when a frame completes while previous byte is unread
// - merge bit 0 routes errors to own request or receive-complete request
// - filtered level changes only when two successive base clock samples agree
// - receive logic lags the pin by two base clocks through the filter
// - break mode starts when trigger bit 6 set with power and receive enabled
// - in break mode a low of 11 bits or more completes and clears mode
// - no overrun, parity or framing detection during break reception
// - break reception never writes the receive buffer, which keeps its last value (FFH after reset)
// - a low of 10 bits or less raises nothing and break mode stays
// - base clock from 4-bit select, only while power is on
// - separate 8-bit divider counters for transmitter and receiver
// - transmit counter held zero unless power and transmit enable
// - transmit counter clears on first write and at back-to-back frame ends
// - receive counter held zero when off, runs from start bit to frame end
// - bit time is twice k base clocks, k from the divider field
// - after a falling edge wait k counts, accept start only if still low
// - on overrun the new byte is dropped, the unread byte is kept
module asu_async_serial_unit
  import asu_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  output var  logic [7:0] reg_rd_data,
  // serial pins and timer source
  input  wire logic       rx_pin,
  output var  logic       tx_pin,
  input  wire logic       timer_out_in,
  // interrupt requests
  output var  logic       rx_complete_irq,
  output var  logic       rx_error_irq,
  output var  logic       tx_complete_irq
);

  // parity of a byte, used by receiver and transmitter
  function automatic logic asu_xor8(input logic [7:0] v);
    asu_xor8 = ^v;
  endfunction : asu_xor8

  // configuration registers
  asu_mode_t  mode_q,   mode_d;
  logic [3:0] clksel_q, clksel_d;
  logic [7:0] baud_q,   baud_d;
  logic       wr_mode, wr_ctrl, wr_txbuf, wr_clksel, wr_baud;
  logic       rd_errst, rd_rxbuf;
  logic       rx_on, tx_on;

  // address decoding of the strobes
  always_comb
  begin
    wr_mode   = reg_wr_en && (reg_addr == ASU_OFS_MODE);
    wr_ctrl   = reg_wr_en && (reg_addr == ASU_OFS_CTRL);
    wr_txbuf  = reg_wr_en && (reg_addr == ASU_OFS_TXBUF);
    wr_clksel = reg_wr_en && (reg_addr == ASU_OFS_CLKSEL);
    wr_baud   = reg_wr_en && (reg_addr == ASU_OFS_BAUD);
    rd_errst  = reg_rd_en && (reg_addr == ASU_OFS_ERRST);
    rd_rxbuf  = reg_rd_en && (reg_addr == ASU_OFS_RXBUF);
    rx_on     = mode_q.unit_power_bit && mode_q.rx_enable_bit;
    tx_on     = mode_q.unit_power_bit && mode_q.tx_enable_bit;
    mode_d    = wr_mode ? asu_mode_t'(reg_wr_data) : mode_q;
    clksel_d  = wr_clksel ? reg_wr_data[3:0] : clksel_q;
    baud_d    = wr_baud ? reg_wr_data : baud_q;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q   <= asu_mode_t'(ASU_RST_MODE);
      clksel_q <= ASU_RST_CLKSEL;
      baud_q   <= ASU_RST_BAUD;
    end
    else
    begin
      mode_q   <= mode_d;
      clksel_q <= clksel_d;
      baud_q   <= baud_d;
    end
  end

  // prescaler, base clock tick and receive noise filter
  logic [9:0] presc_q, presc_d;
  logic       tmr_s1_q, tmr_s2_q, tmr_prev_q;
  logic       rx_s1_q, rx_s2_q;
  logic       smp_a_q, smp_a_d, smp_b_q, smp_b_d;
  logic       filt_q, filt_d, filt_prev_q, filt_prev_d;
  logic [9:0] div_mask;
  logic       tick;

  always_comb
  begin
    presc_d  = mode_q.unit_power_bit ? presc_q + 10'h001 : 10'h000;
    div_mask = 10'((11'h001 << clksel_q) - 11'h001);
    tick     = 1'b0;
    // base clock exists only while powered; sel 0 is the main clock
    if (!mode_q.unit_power_bit)
      tick = 1'b0;
    else if (clksel_q <= ASU_SEL_MAX_DIV)
      tick = ((presc_q & div_mask) == div_mask);
    else if (clksel_q == ASU_SEL_TIMER)
      tick = tmr_s2_q && !tmr_prev_q;
    smp_a_d     = smp_a_q;
    smp_b_d     = smp_b_q;
    filt_d      = filt_q;
    filt_prev_d = filt_prev_q;
    // a one-sample glitch never reaches the receiver
    if (tick)
    begin
      smp_a_d     = rx_s2_q;
      smp_b_d     = smp_a_q;
      filt_prev_d = filt_q;
      if (smp_a_q == smp_b_q)
        filt_d = smp_a_q;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      presc_q     <= 10'h000;
      tmr_s1_q    <= 1'b0;
      tmr_s2_q    <= 1'b0;
      tmr_prev_q  <= 1'b0;
      rx_s1_q     <= 1'b1;
      rx_s2_q     <= 1'b1;
      smp_a_q     <= 1'b1;
      smp_b_q     <= 1'b1;
      filt_q      <= 1'b1;
      filt_prev_q <= 1'b1;
    end
    else
    begin
      presc_q     <= presc_d;
      tmr_s1_q    <= timer_out_in;
      tmr_s2_q    <= tmr_s1_q;
      tmr_prev_q  <= tmr_s2_q;
      rx_s1_q     <= rx_pin;
      rx_s2_q     <= rx_s1_q;
      smp_a_q     <= smp_a_d;
      smp_b_q     <= smp_b_d;
      filt_q      <= filt_d;
      filt_prev_q <= filt_prev_d;
    end
  end

  // receiver, error status, receive buffer and break control
  asu_rx_state_t rx_st_q, rx_st_d;
  logic [7:0] rx_cnt_q, rx_cnt_d;
  logic       rx_half_q, rx_half_d;
  logic [3:0] rx_idx_q, rx_idx_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic       rx_par_q, rx_par_d;
  logic [7:0] rxbuf_q, rxbuf_d;
  logic       rx_full_q, rx_full_d;
  logic [2:0] err_q, err_d;
  logic       brk_trig_q, brk_trig_d;
  logic       rxc_irq_d, rxe_irq_d;
  logic       rx_half_evt, rx_bit_evt;
  logic [7:0] rx_byte;
  logic [2:0] err_set;
  logic [3:0] rx_nbits;

  always_comb
  begin
    rx_st_d     = rx_st_q;
    rx_cnt_d    = rx_cnt_q;
    rx_half_d   = rx_half_q;
    rx_idx_d    = rx_idx_q;
    rx_sh_d     = rx_sh_q;
    rx_par_d    = rx_par_q;
    rxbuf_d     = rxbuf_q;
    rx_full_d   = rx_full_q && !rd_rxbuf;
    brk_trig_d  = brk_trig_q;
    rxc_irq_d   = 1'b0;
    rxe_irq_d   = 1'b0;
    err_set     = 3'h0;
    rx_nbits    = mode_q.char8 ? 4'h8 : 4'h7;
    rx_byte     = mode_q.char8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
    // each wrap of the counter marks half a bit: k ticks
    rx_half_evt = tick && (rx_cnt_q == baud_q - 8'h01);
    rx_bit_evt  = rx_half_evt && rx_half_q;
    if (rx_st_q != RX_IDLE && tick)
      rx_cnt_d = rx_half_evt ? 8'h00 : rx_cnt_q + 8'h01;
    if (rx_half_evt)
      rx_half_d = !rx_half_q;
    // trigger only takes while the receiver is live
    if (wr_ctrl && rx_on)
      brk_trig_d = reg_wr_data[ASU_CTRL_BRK_TRIG];
    case (rx_st_q)
      RX_IDLE:
      begin
        rx_cnt_d  = 8'h00;
        rx_half_d = 1'b0;
        if (filt_prev_q && !filt_q)
          rx_st_d = RX_START;
      end
      RX_START:
        if (rx_half_evt)
        begin
          rx_half_d = 1'b0;
          rx_idx_d  = brk_trig_q ? 4'h1 : 4'h0;
          if (filt_q)
            rx_st_d = RX_IDLE;
          else
            rx_st_d = brk_trig_q ? RX_BRK : RX_DATA;
        end
      RX_DATA:
        if (rx_bit_evt)
        begin
          rx_sh_d  = {filt_q, rx_sh_q[7:1]};
          rx_idx_d = rx_idx_q + 4'h1;
          if (rx_idx_q == rx_nbits - 4'h1)
            rx_st_d = (mode_q.parity == ASU_PAR_NONE) ? RX_STOP : RX_PAR;
        end
      RX_PAR:
        if (rx_bit_evt)
        begin
          rx_par_d = filt_q;
          rx_st_d  = RX_STOP;
        end
      RX_STOP:
        if (rx_bit_evt)
        begin
          rx_st_d = RX_IDLE;
          err_set[ASU_ERR_FRAMING] = !filt_q;
          if (mode_q.parity == ASU_PAR_EVEN)
            err_set[ASU_ERR_PARITY] = asu_xor8(rx_byte) ^ rx_par_q;
          else if (mode_q.parity == ASU_PAR_ODD)
            err_set[ASU_ERR_PARITY] = !(asu_xor8(rx_byte) ^ rx_par_q);
          err_set[ASU_ERR_OVERRUN] = rx_full_q && !rd_rxbuf;
          if (!err_set[ASU_ERR_OVERRUN])
          begin
            rxbuf_d   = rx_byte;
            rx_full_d = 1'b1;
          end
          // errors only reported once the stop position is reached
          if (err_set != 3'h0 && !mode_q.irq_merge_select)
            rxe_irq_d = 1'b1;
          else
            rxc_irq_d = 1'b1;
        end
      RX_BRK:
        // low width counted in bits; no error logic, buffer untouched
        if (rx_bit_evt)
        begin
          if (!filt_q)
            rx_idx_d = (rx_idx_q == 4'hF) ? rx_idx_q : rx_idx_q + 4'h1;
          else
          begin
            rx_st_d = RX_IDLE;
            if (rx_idx_q >= ASU_BRK_MIN_LOW)
            begin
              rxc_irq_d  = 1'b1;
              brk_trig_d = 1'b0;
            end
          end
        end
      default:
        rx_st_d = RX_IDLE;
    endcase
    // turning the receiver off stops it and ends break mode
    if (!rx_on)
    begin
      rx_st_d    = RX_IDLE;
      rx_cnt_d   = 8'h00;
      rx_half_d  = 1'b0;
      brk_trig_d = 1'b0;
      rxc_irq_d  = 1'b0;
      rxe_irq_d  = 1'b0;
      err_set    = 3'h0;
    end
    // read clears, but a flag set in the same cycle survives
    err_d = (rd_errst ? 3'h0 : err_q) | err_set;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_st_q         <= RX_IDLE;
      rx_cnt_q        <= 8'h00;
      rx_half_q       <= 1'b0;
      rx_idx_q        <= 4'h0;
      rx_sh_q         <= 8'h00;
      rx_par_q        <= 1'b0;
      rxbuf_q         <= ASU_RST_RXBUF;
      rx_full_q       <= 1'b0;
      err_q           <= 3'h0;
      brk_trig_q      <= 1'b0;
      rx_complete_irq <= 1'b0;
      rx_error_irq    <= 1'b0;
    end
    else
    begin
      rx_st_q         <= rx_st_d;
      rx_cnt_q        <= rx_cnt_d;
      rx_half_q       <= rx_half_d;
      rx_idx_q        <= rx_idx_d;
      rx_sh_q         <= rx_sh_d;
      rx_par_q        <= rx_par_d;
      rxbuf_q         <= rxbuf_d;
      rx_full_q       <= rx_full_d;
      err_q           <= err_d;
      brk_trig_q      <= brk_trig_d;
      rx_complete_irq <= rxc_irq_d;
      rx_error_irq    <= rxe_irq_d;
    end
  end

  // transmitter with its one-byte buffer
  asu_tx_state_t tx_st_q, tx_st_d;
  logic [7:0]  tx_cnt_q, tx_cnt_d;
  logic        tx_half_q, tx_half_d;
  logic [11:0] tx_sh_q, tx_sh_d;
  logic [3:0]  tx_left_q, tx_left_d;
  logic [7:0]  txbuf_q, txbuf_d;
  logic        tx_full_q, tx_full_d;
  logic        tx_pin_d, txc_irq_d;
  logic        tx_bit_evt, tx_load;
  logic [7:0]  tx_src;
  logic [11:0] tx_frame;
  logic [3:0]  tx_len;
  logic        tx_pbit;

  always_comb
  begin
    tx_st_d    = tx_st_q;
    tx_half_d  = tx_half_q;
    tx_sh_d    = tx_sh_q;
    tx_left_d  = tx_left_q;
    txbuf_d    = txbuf_q;
    tx_full_d  = tx_full_q;
    txc_irq_d  = 1'b0;
    tx_load    = 1'b0;
    tx_src     = txbuf_q;
    tx_bit_evt = tick && (tx_cnt_q == baud_q - 8'h01) && tx_half_q;
    // counter runs freely while enabled, also after the last frame
    tx_cnt_d   = tx_cnt_q;
    if (tick)
    begin
      tx_cnt_d = (tx_cnt_q == baud_q - 8'h01) ? 8'h00
                                               : tx_cnt_q + 8'h01;
      if (tx_cnt_q == baud_q - 8'h01)
        tx_half_d = !tx_half_q;
    end
    if (wr_txbuf && tx_on)
    begin
      if (tx_st_q == TX_IDLE)
      begin
        tx_load = 1'b1;
        tx_src  = reg_wr_data;
      end
      else
      begin
        txbuf_d   = reg_wr_data;
        tx_full_d = 1'b1;
      end
    end
    if (tx_st_q == TX_SHIFT && tx_bit_evt)
    begin
      tx_sh_d   = {1'b1, tx_sh_q[11:1]};
      tx_left_d = tx_left_q - 4'h1;
      if (tx_left_q == 4'h1)
      begin
        txc_irq_d = 1'b1;
        tx_st_d   = TX_IDLE;
        if (tx_full_d)
        begin
          tx_load   = 1'b1;
          tx_src    = txbuf_d;
          tx_full_d = 1'b0;
        end
      end
    end
    // frame: start, data lsb first, optional parity, stop bits
    tx_pbit  = (mode_q.parity == ASU_PAR_ODD) ? !asu_xor8(tx_src)
             : (mode_q.parity == ASU_PAR_EVEN) ? asu_xor8(tx_src)
             : 1'b0;
    tx_frame = mode_q.char8 ? {2'b11, tx_pbit, tx_src, 1'b0}
                            : {3'b111, tx_pbit, tx_src[6:0], 1'b0};
    if (mode_q.parity == ASU_PAR_NONE)
      tx_frame = mode_q.char8 ? {3'b111, tx_src, 1'b0}
                              : {4'b1111, tx_src[6:0], 1'b0};
    tx_len = 4'h2 + (mode_q.char8 ? 4'h8 : 4'h7)
           + ((mode_q.parity != ASU_PAR_NONE) ? 4'h1 : 4'h0)
           + (mode_q.stop2 ? 4'h1 : 4'h0);
    if (tx_load)
    begin
      tx_st_d   = TX_SHIFT;
      tx_sh_d   = tx_frame;
      tx_left_d = tx_len;
      tx_cnt_d  = 8'h00;
      tx_half_d = 1'b0;
    end
    // disabled transmitter: counter pinned at zero, data dropped
    if (!tx_on)
    begin
      tx_st_d   = TX_IDLE;
      tx_cnt_d  = 8'h00;
      tx_half_d = 1'b0;
      tx_full_d = 1'b0;
      txc_irq_d = 1'b0;
    end
    tx_pin_d = (tx_st_d == TX_SHIFT) ? tx_sh_d[0] : 1'b1;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_st_q         <= TX_IDLE;
      tx_cnt_q        <= 8'h00;
      tx_half_q       <= 1'b0;
      tx_sh_q         <= 12'hFFF;
      tx_left_q       <= 4'h0;
      txbuf_q         <= 8'h00;
      tx_full_q       <= 1'b0;
      tx_pin          <= 1'b1;
      tx_complete_irq <= 1'b0;
    end
    else
    begin
      tx_st_q         <= tx_st_d;
      tx_cnt_q        <= tx_cnt_d;
      tx_half_q       <= tx_half_d;
      tx_sh_q         <= tx_sh_d;
      tx_left_q       <= tx_left_d;
      txbuf_q         <= txbuf_d;
      tx_full_q       <= tx_full_d;
      tx_pin          <= tx_pin_d;
      tx_complete_irq <= txc_irq_d;
    end
  end

  // read data, valid the cycle after the read strobe
  logic [7:0] rd_data_d;

  always_comb
  begin
    rd_data_d = 8'h00;
    if (!reg_rd_en)
      rd_data_d = 8'h00;
    else if (reg_addr == ASU_OFS_MODE)
      rd_data_d = mode_q;
    else if (reg_addr == ASU_OFS_CTRL)
    begin
      rd_data_d[ASU_CTRL_BRK_FLAG] = brk_trig_q;
      rd_data_d[ASU_CTRL_BRK_TRIG] = brk_trig_q;
    end
    else if (reg_addr == ASU_OFS_ERRST)
      rd_data_d = {5'h00, err_q};
    else if (reg_addr == ASU_OFS_RXBUF)
      rd_data_d = rxbuf_q;
    else if (reg_addr == ASU_OFS_TXBUF)
      rd_data_d = txbuf_q;
    else if (reg_addr == ASU_OFS_TXSTAT)
    begin
      rd_data_d[ASU_TXST_BUSY] = (tx_st_q == TX_SHIFT);
      rd_data_d[ASU_TXST_FULL] = tx_full_q;
    end
    else if (reg_addr == ASU_OFS_CLKSEL)
      rd_data_d = {4'h0, clksel_q};
    else
      rd_data_d = baud_q;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rd_data <= 8'h00;
    else
      reg_rd_data <= rd_data_d;
  end

endmodule : asu_async_serial_unit

`default_nettype wire

// ===== asu_async_serial_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module asu_async_serial_unit_tb;
  import asu_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_rd_data;
  logic        rx_pin;
  logic        tx_pin;
  logic        timer_out_in = 1'b0;
  logic        rx_complete_irq;
  logic        rx_error_irq;
  logic        tx_complete_irq;
  logic [7:0]  rd_v;
  logic        pe;
  logic [31:0] lfsr = 32'hB2E93769;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n_rxc = 0;
  int          n_rxe = 0;
  int          n_txc = 0;
  int          e_rxc = 0;
  int          e_rxe = 0;
  asu_async_serial_unit u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .timer_out_in(timer_out_in),
    .rx_complete_irq(rx_complete_irq), .rx_error_irq(rx_error_irq),
    .tx_complete_irq(tx_complete_irq));
  asu_remote_node u_node (.clk_sys(clk_sys), .line_in(tx_pin),
    .line_out(rx_pin));
  always #50 clk_sys = ~clk_sys;
  // request counters, timer source and the hang limit
  always @(posedge clk_sys)
  begin
    timer_out_in <= ~timer_out_in;
    n_rxc <= n_rxc + int'(rx_complete_irq);
    n_rxe <= n_rxe + int'(rx_error_irq);
    n_txc <= n_txc + int'(tx_complete_irq);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    @(negedge clk_sys);
    rd_v = reg_rd_data;
    chk(w, {8'h00, e}, {8'h00, rd_v});
  endtask : rc
  task automatic irqs();
    chk("rx done irqs", 16'(e_rxc), 16'(n_rxc));
    chk("rx error irqs", 16'(e_rxe), 16'(n_rxe));
  endtask : irqs
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    // powered off: trigger refused, a frame goes unseen
    rc(ASU_OFS_MODE, ASU_RST_MODE, "mode");
    rc(ASU_OFS_BAUD, ASU_RST_BAUD, "divider");
    wr(ASU_OFS_CTRL, 8'h40);
    rc(ASU_OFS_CTRL, 8'h00, "ctrl");
    u_node.send(8'h00, ASU_PAR_NONE, 1'b0, 1'b0);
    irqs();
    wr(ASU_OFS_BAUD, 8'h0A);
    wr(ASU_OFS_MODE, 8'hFC);
    // break: ten bits low is ignored, thirteen completes it
    wr(ASU_OFS_CTRL, 8'h40);
    rc(ASU_OFS_CTRL, 8'hC0, "ctrl");
    u_node.put(1'b0, 200);
    u_node.put(1'b1, 80);
    irqs();
    rc(ASU_OFS_CTRL, 8'hC0, "ctrl");
    u_node.put(1'b0, 260);
    u_node.put(1'b1, 80);
    e_rxc++;
    irqs();
    rc(ASU_OFS_CTRL, 8'h00, "ctrl");
    rc(ASU_OFS_ERRST, 8'h00, "errst");
    rc(ASU_OFS_RXBUF, ASU_RST_RXBUF, "rxbuf");
    // every parity mode with a good and a flipped parity bit
    for (int m = 0; m < 4; m++)
      for (int f = 0; f < 2; f++)
      begin
        lfsr = lfsr_next(lfsr);
        wr(ASU_OFS_MODE, {3'b111, 2'(m), 3'b100});
        u_node.send(lfsr[7:0], 2'(m), f == 1, 1'b0);
        pe = f == 1 && m >= 2;
        e_rxe += int'(pe);
        e_rxc += int'(!pe);
        irqs();
        rc(ASU_OFS_ERRST, {5'h00, pe, 2'b00}, "errst");
        rc(ASU_OFS_RXBUF, lfsr[7:0], "rxbuf");
      end
    // merged: a bad stop bit, then two frames left unread
    wr(ASU_OFS_MODE, 8'hFD);
    u_node.send(8'hA5, ASU_PAR_EVEN, 1'b0, 1'b1);
    rc(ASU_OFS_ERRST, 8'h02, "errst");
    rc(ASU_OFS_RXBUF, 8'hA5, "rxbuf");
    u_node.send(8'h3C, ASU_PAR_EVEN, 1'b0, 1'b0);
    u_node.send(8'hC3, ASU_PAR_EVEN, 1'b0, 1'b0);
    e_rxc += 3;
    irqs();
    rc(ASU_OFS_ERRST, 8'h01, "errst");
    rc(ASU_OFS_ERRST, 8'h00, "errst");
    rc(ASU_OFS_RXBUF, 8'h3C, "rxbuf");
    // glitches shorter than the filter and than the start check
    u_node.put(1'b0, 1);
    u_node.put(1'b1, 40);
    u_node.put(1'b0, 5);
    u_node.put(1'b1, 300);
    irqs();
    // timer output as base clock, one tick per two clocks
    lfsr = lfsr_next(lfsr);
    wr(ASU_OFS_CLKSEL, ASU_SEL_TIMER);
    u_node.bitc = 40;
    u_node.send(lfsr[7:0], ASU_PAR_EVEN, 1'b0, 1'b0);
    e_rxc++;
    irqs();
    rc(ASU_OFS_RXBUF, lfsr[7:0], "rxbuf");
    wr(ASU_OFS_CLKSEL, 8'h00);
    u_node.bitc = 20;
    // two bytes back to back, then transmitter disabled
    wr(ASU_OFS_TXBUF, lfsr[15:8]);
    rc(ASU_OFS_TXSTAT, 8'h01, "txstat");
    wr(ASU_OFS_TXBUF, lfsr[23:16]);
    rc(ASU_OFS_TXSTAT, 8'h03, "txstat");
    repeat (500) @(posedge clk_sys);
    chk("tx irqs", 16'd2, 16'(n_txc));
    chk("tx byte", {8'h00, lfsr[15:8]}, {8'h00, u_node.got_q.pop_front()});
    chk("tx byte", {8'h00, lfsr[23:16]}, {8'h00, u_node.got_q.pop_front()});
    wr(ASU_OFS_MODE, 8'hBD);
    wr(ASU_OFS_TXBUF, 8'h5A);
    rc(ASU_OFS_TXSTAT, 8'h00, "txstat");
    // break sent as 00H with the divider raised from 10 to 13
    wr(ASU_OFS_MODE, 8'hFD);
    wr(ASU_OFS_BAUD, 8'h0D);
    u_node.bitc = 26;
    wr(ASU_OFS_TXBUF, 8'h00);
    repeat (320) @(posedge clk_sys);
    chk("break low", 16'd260, 16'(u_node.last_low));
    chk("tx irqs", 16'd3, 16'(n_txc));
    print_verdict();
  end
endmodule : asu_async_serial_unit_tb
`default_nettype wire

// ===== asu_pkg.sv
package asu_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] ASU_OFS_MODE   = 3'h0;
  localparam logic [2:0] ASU_OFS_CTRL   = 3'h1;
  localparam logic [2:0] ASU_OFS_ERRST  = 3'h2;
  localparam logic [2:0] ASU_OFS_RXBUF  = 3'h3;
  localparam logic [2:0] ASU_OFS_TXBUF  = 3'h4;
  localparam logic [2:0] ASU_OFS_TXSTAT = 3'h5;
  localparam logic [2:0] ASU_OFS_CLKSEL = 3'h6;
  localparam logic [2:0] ASU_OFS_BAUD   = 3'h7;

  // field positions
  localparam int ASU_CTRL_BRK_FLAG = 7;
  localparam int ASU_CTRL_BRK_TRIG = 6;
  localparam int ASU_ERR_OVERRUN   = 0;
  localparam int ASU_ERR_FRAMING   = 1;
  localparam int ASU_ERR_PARITY    = 2;
  localparam int ASU_TXST_BUSY     = 0;
  localparam int ASU_TXST_FULL     = 1;

  // reset values
  localparam logic [7:0] ASU_RST_MODE   = 8'h01;
  localparam logic [7:0] ASU_RST_RXBUF  = 8'hFF;
  localparam logic [3:0] ASU_RST_CLKSEL = 4'h0;
  localparam logic [7:0] ASU_RST_BAUD   = 8'hFF;

  // base clock selection and break detection figures
  localparam logic [3:0] ASU_SEL_MAX_DIV = 4'hA;
  localparam logic [3:0] ASU_SEL_TIMER   = 4'hB;
  localparam logic [3:0] ASU_BRK_MIN_LOW = 4'hB;

  // parity modes
  localparam logic [1:0] ASU_PAR_NONE = 2'h0;
  localparam logic [1:0] ASU_PAR_ZERO = 2'h1;
  localparam logic [1:0] ASU_PAR_ODD  = 2'h2;
  localparam logic [1:0] ASU_PAR_EVEN = 2'h3;

  // serial_mode_reg layout, msb first
  typedef struct packed {
    logic       unit_power_bit;
    logic       tx_enable_bit;
    logic       rx_enable_bit;
    logic [1:0] parity;
    logic       char8;
    logic       stop2;
    logic       irq_merge_select;
  } asu_mode_t;

  // receiver and transmitter states
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK
  } asu_rx_state_t;

  typedef enum logic {TX_IDLE, TX_SHIFT} asu_tx_state_t;

endpackage : asu_pkg

// ===== asu_props.sv
`timescale 1ns/1ns
`default_nettype none
module asu_props
  import asu_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  // line and requests
  input wire logic       tx_pin,
  input wire logic       rx_complete_irq,
  input wire logic       rx_error_irq,
  input wire logic       tx_complete_irq
);
  asu_mode_t  mode_q;
  logic [7:0] k_q;
  logic [3:0] sel_q;
  logic [9:0] low_q;
  logic       pw;
  logic       tx_on;
  logic       merge;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  assign pw    = mode_q.unit_power_bit;
  assign tx_on = pw && mode_q.tx_enable_bit;
  assign merge = mode_q.irq_merge_select;
  // shadow settings; low_q is the length of the current low run on tx
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      mode_q <= ASU_RST_MODE;
      k_q    <= ASU_RST_BAUD;
      sel_q  <= ASU_RST_CLKSEL;
      low_q  <= 10'h000;
    end
    else
    begin
      if (reg_wr_en && reg_addr == ASU_OFS_MODE) mode_q <= reg_wr_data;
      if (reg_wr_en && reg_addr == ASU_OFS_BAUD) k_q <= reg_wr_data;
      if (reg_wr_en && reg_addr == ASU_OFS_CLKSEL) sel_q <= reg_wr_data[3:0];
      low_q <= tx_pin ? 10'h000 : low_q + 10'h001;
    end
  sequence s_err_rd;
    reg_rd_en && reg_addr == ASU_OFS_ERRST;
  endsequence
  property p_rd_idle;
    !reg_rd_en |=> reg_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_errst_clear;
    s_err_rd ##1 (!reg_rd_en && !rx_error_irq && !rx_complete_irq)
      ##1 s_err_rd ##0 (!rx_error_irq && !rx_complete_irq)
      |=> reg_rd_data == 8'h00;
  endproperty
  a_errst_clear: assert property (p_errst_clear)
    else $error("error status not cleared by read");
  property p_irq_excl;
    !(rx_complete_irq && rx_error_irq);
  endproperty
  a_irq_excl: assert property (p_irq_excl)
    else $error("both receive requests at once");
  property p_err_split;
    rx_error_irq |-> !$past(merge);
  endproperty
  a_err_split: assert property (p_err_split)
    else $error("error request while merged");
  property p_pulse;
    ((rx_complete_irq || rx_error_irq) |=> !(rx_complete_irq || rx_error_irq))
      and (tx_complete_irq |=> !tx_complete_irq);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("request longer than one cycle");
  property p_off_quiet;
    !pw && !$past(pw) |-> !rx_complete_irq && !rx_error_irq;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("receive request while powered off");
  property p_tx_hold;
    !tx_on && !$past(tx_on) |-> tx_pin && !tx_complete_irq;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmitter active while disabled");
  // with select 0 a tick is one clock, so every low run is n times 2k
  property p_tx_bit_time;
    $rose(tx_pin) && sel_q == 4'h0 && tx_on && $past(tx_on) |->
      (low_q % {1'b0, k_q, 1'b0}) == 10'h000;
  endproperty
  a_tx_bit_time: assert property (p_tx_bit_time)
    else $error("tx low run not a whole number of bits");
endmodule : asu_props

bind asu_async_serial_unit asu_props u_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .tx_pin(tx_pin),
  .rx_complete_irq(rx_complete_irq), .rx_error_irq(rx_error_irq),
  .tx_complete_irq(tx_complete_irq));
`default_nettype wire

// ===== asu_remote_node.sv
`timescale 1ns/1ns
`default_nettype none
module asu_remote_node
  import asu_pkg::*;
(
  // clock
  input  wire logic clk_sys,
  // serial line
  input  wire logic line_in,
  output var  logic line_out
);
  int         bitc = 20;
  int         low_cnt = 0;
  int         last_low = 0;
  logic [7:0] got_q[$];
  logic [7:0] b;
  initial line_out = 1'b1;
  // one cell of n clocks; the line idles high between frames
  task automatic put(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge clk_sys);
  endtask : put
  // start, data lsb first, parity slot if any, stop, one idle cell
  task automatic send(input logic [7:0] d, input logic [1:0] pm,
                      input logic bp, input logic bs);
    logic p;
    p = (pm == ASU_PAR_ODD) ? ~^d : (pm == ASU_PAR_EVEN) & ^d;
    put(1'b0, bitc);
    for (int i = 0; i < 8; i++)
      put(d[i], bitc);
    if (pm != ASU_PAR_NONE)
      put(p ^ bp, bitc);
    put(~bs, bitc);
    put(1'b1, bitc);
  endtask : send
  // decode what the unit sends; assumes a parity slot is present
  always
  begin
    @(negedge line_in);
    repeat (bitc / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bitc) @(posedge clk_sys);
      b[i] = line_in;
    end
    repeat (bitc) @(posedge clk_sys);
    wait (line_in);
    got_q.push_back(b);
  end
  // length of the last low run, used to time a transmitted break
  always @(posedge clk_sys)
  begin
    if (line_in && low_cnt != 0) last_low <= low_cnt;
    low_cnt <= line_in ? 0 : low_cnt + 1;
  end
endmodule : asu_remote_node
`default_nettype wire
